/* pdt_pkg.sv */
// Package of constants and types for the automatic dead-time unit
`default_nettype none
package pdt_pkg;
  typedef logic [15:0] pdt_val_t;
  typedef logic [16:0] pdt_wide_t;
  typedef logic [7:0] pdt_addr_t;

  // ************************************************************
  // Register byte offsets
  // ************************************************************
  localparam pdt_addr_t OFS_CTRL = 8'h00;
  localparam pdt_addr_t OFS_STATUS = 8'h04;
  localparam pdt_addr_t OFS_POS_CMP = 8'h08;
  localparam pdt_addr_t OFS_NEG_CMP = 8'h0c;
  localparam pdt_addr_t OFS_DT_FIRST = 8'h10;
  localparam pdt_addr_t OFS_DT_SECOND = 8'h14;
  localparam pdt_addr_t OFS_DT_FIRST_BUF = 8'h18;
  localparam pdt_addr_t OFS_DT_SECOND_BUF = 8'h1c;
  localparam pdt_addr_t OFS_PERIOD = 8'h20;
  localparam pdt_addr_t OFS_COUNT = 8'h24;

  // ************************************************************
  // Field layouts
  // ************************************************************
  typedef struct packed {
    logic clear;
    logic [2:0] mode;
    logic buf_second_en;
    logic buf_first_en;
    logic same_sel;
    logic auto_en;
    logic run;
  } pdt_ctrl_s;

  typedef struct packed {
    logic order_unsafe;
    logic protect_active;
    logic dead_time_err;
    logic dir_down;
  } pdt_stat_s;

  localparam int CTRL_W = 9;
  localparam int STAT_W = 4;

  // ************************************************************
  // Modes, reset values, fixed figures
  // ************************************************************
  localparam logic [2:0] MODE_SAW_UP = 3'h0;
  localparam logic [2:0] MODE_SAW_DN = 3'h1;
  localparam logic [2:0] MODE_TRI1 = 3'h2;
  localparam logic [2:0] MODE_TRI2 = 3'h3;
  localparam logic [2:0] MODE_TRI3 = 3'h4;

  localparam pdt_ctrl_s CTRL_RST = '0;
  localparam pdt_val_t PERIOD_RST = 16'hffff;
  localparam pdt_val_t VAL_ZERO = 16'h0000;
  localparam pdt_val_t VAL_ONE = 16'h0001;
endpackage
`default_nettype wire

/* pdt_auto_dead_time.sv */
// Automatic dead-time unit of one PWM timer channel with APB register access
// Functional notes
// RL1: Auto negative compare only in allowed modes
// RL2: First-half and second-half dead times applied separately
// RL3: Same-select uses first-half time for both
// RL4: Buffers load at cycle end or trough
// RL5: Negative compare reads back computed value
// RL6: Software never writes negative compare in auto
// RL7: Software keeps dead time within the cycle
// RL8: Errors adjust negative register, positive kept
// RL9: Saw up errors clamp to 0 or period
// RL10: Saw down errors clamp to period or 0
// RL11: Triangle errors clamp to 1 or 0
// RL12: One-shot disorder flagged, complementarity not guaranteed
// RL13: Triangle out-of-range positive holds output level
// RL14: Huge positive value limits negative to period-1
// RL15: Negative compare refreshed on next clock
// RL16: Positive compare valid in range at start
// RL17: Out-of-range positive deactivates one output
// RL18: Positive compare limits at buffer transfers
// RL19: Triangle positive above dead times, below period
`default_nettype none
module pdt_auto_dead_time (
  // APB slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire pdt_pkg::pdt_addr_t paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Complementary outputs to the switching stage
  output logic pwm_pos,
  output logic pwm_neg
);
  import pdt_pkg::*;
  // ************************************************************
  // Register bus
  // ************************************************************
  pdt_ctrl_s ctrl_reg;
  pdt_stat_s stat;
  pdt_val_t pos_reg, neg_reg, dtf_reg, dts_reg, dtf_buf_reg, dts_buf_reg, period_reg, cnt_reg;
  pdt_val_t pos_adj_reg, neg_calc, pos_adj_calc, dv_first, dv_second;
  logic clr_reg, dir_down_reg, dt_err_reg, order_reg, dt_err, order_bad;
  logic wr_en, setup_rd, addr_ok, saw_mode, tri_mode, auto_ok, xfer_evt, protect;
  logic [31:0] rd_mux;
  assign wr_en = psel & penable & pwrite;
  assign setup_rd = psel & ~penable & ~pwrite;
  // Zero-wait slave: every access completes in its first access cycle
  assign pready = 1'b1;
  always_comb begin
    addr_ok = 1'b1;
    rd_mux = '0;
    case (paddr)
      OFS_CTRL: rd_mux = {{(32 - CTRL_W){1'b0}}, ctrl_reg};
      OFS_STATUS: rd_mux = {{(32 - STAT_W){1'b0}}, stat};
      OFS_POS_CMP: rd_mux = {16'h0000, pos_reg};
      OFS_NEG_CMP: rd_mux = {16'h0000, neg_reg}; // see RL5
      OFS_DT_FIRST: rd_mux = {16'h0000, dtf_reg};
      OFS_DT_SECOND: rd_mux = {16'h0000, dts_reg};
      OFS_DT_FIRST_BUF: rd_mux = {16'h0000, dtf_buf_reg};
      OFS_DT_SECOND_BUF: rd_mux = {16'h0000, dts_buf_reg};
      OFS_PERIOD: rd_mux = {16'h0000, period_reg};
      OFS_COUNT: rd_mux = {16'h0000, cnt_reg};
      default: addr_ok = 1'b0;
    endcase
  end
  assign pslverr = psel & penable & ~addr_ok;
  // Read data captured in the setup cycle so it stands as a flop output
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (setup_rd) begin
      prdata <= rd_mux;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= CTRL_RST;
    end else if (wr_en && paddr == OFS_CTRL) begin
      ctrl_reg <= pdt_ctrl_s'({pwdata[CTRL_W-1:0] & {1'b0, {(CTRL_W - 1){1'b1}}}});
    end
  end
  // Counter clear is a write-only strobe, never stored in the control word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clr_reg <= 1'b0;
    end else begin
      clr_reg <= wr_en && paddr == OFS_CTRL && pwdata[CTRL_W-1];
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pos_reg <= VAL_ZERO;
      dtf_buf_reg <= VAL_ZERO;
      dts_buf_reg <= VAL_ZERO;
      period_reg <= PERIOD_RST;
    end else if (wr_en) begin
      case (paddr)
        OFS_POS_CMP: pos_reg <= pwdata[15:0];
        OFS_DT_FIRST_BUF: dtf_buf_reg <= pwdata[15:0];
        OFS_DT_SECOND_BUF: dts_buf_reg <= pwdata[15:0];
        OFS_PERIOD: period_reg <= pwdata[15:0];
        default: ;
      endcase
    end
  end

  // ************************************************************
  // Timer counter and transfer events
  // ************************************************************
  assign saw_mode = ctrl_reg.mode == MODE_SAW_UP || ctrl_reg.mode == MODE_SAW_DN;
  assign tri_mode = ctrl_reg.mode == MODE_TRI1 || ctrl_reg.mode == MODE_TRI2 || ctrl_reg.mode == MODE_TRI3;
  assign auto_ok = ctrl_reg.auto_en & (saw_mode | tri_mode); // see RL1
  // Saw cycle end, counter clear in saw modes, or the triangle trough
  assign xfer_evt = clr_reg ? saw_mode : ctrl_reg.run && ( // see RL4
    (ctrl_reg.mode == MODE_SAW_UP && cnt_reg == period_reg) ||
    (ctrl_reg.mode == MODE_SAW_DN && cnt_reg == VAL_ZERO) ||
    (tri_mode && dir_down_reg && cnt_reg == VAL_ZERO));
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= VAL_ZERO;
      dir_down_reg <= 1'b0;
    end else if (clr_reg) begin
      cnt_reg <= (ctrl_reg.mode == MODE_SAW_DN) ? period_reg : VAL_ZERO;
      dir_down_reg <= ctrl_reg.mode == MODE_SAW_DN;
    end else if (ctrl_reg.run) begin
      if (tri_mode) begin
        if (!dir_down_reg) begin
          dir_down_reg <= cnt_reg == period_reg;
          cnt_reg <= (cnt_reg == period_reg) ? cnt_reg - VAL_ONE : cnt_reg + VAL_ONE;
        end else begin
          dir_down_reg <= cnt_reg != VAL_ZERO;
          cnt_reg <= (cnt_reg == VAL_ZERO) ? cnt_reg + VAL_ONE : cnt_reg - VAL_ONE;
        end
      end else if (ctrl_reg.mode == MODE_SAW_DN) begin
        dir_down_reg <= 1'b1;
        cnt_reg <= (cnt_reg == VAL_ZERO) ? period_reg : cnt_reg - VAL_ONE;
      end else begin
        dir_down_reg <= 1'b0;
        cnt_reg <= (cnt_reg == period_reg) ? VAL_ZERO : cnt_reg + VAL_ONE;
      end
    end
  end

  // ************************************************************
  // Dead-time values and their buffers
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dtf_reg <= VAL_ZERO;
    end else if (xfer_evt && ctrl_reg.buf_first_en) begin
      dtf_reg <= dtf_buf_reg; // see RL4
    end else if (wr_en && paddr == OFS_DT_FIRST) begin
      dtf_reg <= pwdata[15:0];
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dts_reg <= VAL_ZERO;
    end else if (xfer_evt && ctrl_reg.buf_second_en) begin
      dts_reg <= dts_buf_reg; // see RL4
    end else if (wr_en && paddr == OFS_DT_SECOND) begin
      dts_reg <= pwdata[15:0];
    end
  end
  assign dv_first = dtf_reg;
  assign dv_second = ctrl_reg.same_sel ? dtf_reg : dts_reg; // see RL3
  // ************************************************************
  // Compare value calculation with dead-time error clamping
  // ************************************************************
  always_comb begin
    pdt_wide_t a, pr, df, ds;
    a = {1'b0, pos_reg};
    pr = {1'b0, period_reg};
    df = {1'b0, dv_first};
    ds = {1'b0, dv_second};
    dt_err = 1'b0;
    order_bad = 1'b0;
    pos_adj_calc = pos_reg;
    neg_calc = neg_reg;
    // First half uses the first-half time, second half the second-half time
    if (ctrl_reg.mode == MODE_SAW_UP) begin // see RL2
      if (a < df) begin
        dt_err = 1'b1; // see RL9
        pos_adj_calc = dv_first;
        neg_calc = VAL_ZERO;
      end else if (a + ds > pr) begin
        dt_err = 1'b1; // see RL9
        pos_adj_calc = period_reg - dv_second;
        neg_calc = period_reg;
      end else begin
        neg_calc = pos_reg - dv_first;
      end
    end else if (ctrl_reg.mode == MODE_SAW_DN) begin
      if (a + df > pr) begin
        dt_err = 1'b1; // see RL10
        pos_adj_calc = period_reg - dv_first;
        neg_calc = period_reg;
      end else if (a < ds) begin
        dt_err = 1'b1; // see RL10
        pos_adj_calc = dv_second;
        neg_calc = VAL_ZERO;
      end else begin
        neg_calc = pos_reg + dv_first;
      end
    end else if (!dir_down_reg) begin
      if (a >= pr + df) begin
        dt_err = 1'b1;
        neg_calc = period_reg - VAL_ONE; // see RL14
      end else if (a <= df) begin
        dt_err = 1'b1; // see RL11
        pos_adj_calc = dv_first + VAL_ONE;
        neg_calc = VAL_ONE;
      end else begin
        neg_calc = pos_reg - dv_first;
      end
    end else begin
      if (a >= pr + ds) begin
        dt_err = 1'b1;
        neg_calc = period_reg - VAL_ONE; // see RL14
      end else if (a < ds) begin
        dt_err = 1'b1; // see RL11
        pos_adj_calc = dv_second;
        neg_calc = VAL_ZERO;
      end else begin
        neg_calc = pos_reg - dv_second;
      end
    end
    // One-shot waveforms past the cycle or with crossed edges are not complementary
    order_bad = saw_mode && ({1'b0, pos_adj_calc} > pr || df + ds > pr); // see RL12
  end
  // Refreshed every clock while auto_ok, so any register change shows one clock later
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      neg_reg <= VAL_ZERO;
    end else if (auto_ok) begin
      neg_reg <= neg_calc; // see RL15 RL8
    end else if (wr_en && paddr == OFS_NEG_CMP) begin
      neg_reg <= pwdata[15:0];
    end
  end
  // Adjusted positive value stays internal; the positive register is untouched
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pos_adj_reg <= VAL_ZERO;
      dt_err_reg <= 1'b0;
      order_reg <= 1'b0;
    end else begin
      pos_adj_reg <= auto_ok ? pos_adj_calc : pos_reg; // see RL8
      dt_err_reg <= auto_ok & dt_err;
      order_reg <= auto_ok & order_bad;
    end
  end

  // ************************************************************
  // Output protection and output stage
  // ************************************************************
  assign protect = tri_mode && ctrl_reg.run && (pos_reg == VAL_ZERO || pos_reg >= period_reg); // see RL13 RL17
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm_pos <= 1'b0;
      pwm_neg <= 1'b0;
    end else if (protect) begin
      pwm_neg <= 1'b0; // see RL17 RL13
    end else if (ctrl_reg.run) begin
      pwm_pos <= cnt_reg >= pos_adj_reg;
      pwm_neg <= cnt_reg < neg_reg;
    end else begin
      pwm_pos <= 1'b0;
      pwm_neg <= 1'b0;
    end
  end
  assign stat = '{order_unsafe: order_reg, protect_active: protect, dead_time_err: dt_err_reg,
                  dir_down: dir_down_reg};
  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_auto_gate;
    !auto_ok && !(wr_en && paddr == OFS_NEG_CMP) |=> $stable(neg_reg);
  endproperty
  a_auto_gate: assert property (p_auto_gate) else $error("negative compare moved outside auto mode"); // see RL1
  property p_refresh;
    auto_ok |=> neg_reg == $past(neg_calc);
  endproperty
  a_refresh: assert property (p_refresh) else $error("negative compare not refreshed"); // see RL15
  property p_same;
    auto_ok && ctrl_reg.same_sel && ctrl_reg.mode == MODE_SAW_DN && pos_reg >= dtf_reg
      && {1'b0, pos_reg} + {1'b0, dtf_reg} <= {1'b0, period_reg} |=> neg_reg == $past(pos_reg) + $past(dtf_reg);
  endproperty
  a_same: assert property (p_same) else $error("same dead time not applied"); // see RL3
  property p_buf;
    xfer_evt && ctrl_reg.buf_first_en |=> dtf_reg == $past(dtf_buf_reg);
  endproperty
  a_buf: assert property (p_buf) else $error("first-half buffer not transferred"); // see RL4
  property p_read_neg;
    setup_rd && paddr == OFS_NEG_CMP ##1 psel && penable |-> prdata[15:0] == $past(neg_reg);
  endproperty
  a_read_neg: assert property (p_read_neg) else $error("negative compare readback wrong"); // see RL5
  property p_pos_kept;
    auto_ok && ctrl_reg.mode == MODE_SAW_UP && pos_reg < dv_first && !wr_en
      |=> pos_adj_reg == $past(dv_first) && $stable(pos_reg);
  endproperty
  a_pos_kept: assert property (p_pos_kept) else $error("positive compare altered by clamp"); // see RL8
  property p_saw_up;
    auto_ok && ctrl_reg.mode == MODE_SAW_UP && pos_reg < dv_first |=> neg_reg == VAL_ZERO && dt_err_reg;
  endproperty
  a_saw_up: assert property (p_saw_up) else $error("saw up clamp wrong"); // see RL9
  property p_saw_dn;
    auto_ok && ctrl_reg.mode == MODE_SAW_DN && {1'b0, pos_reg} + {1'b0, dv_first} > {1'b0, period_reg}
      |=> neg_reg == $past(period_reg);
  endproperty
  a_saw_dn: assert property (p_saw_dn) else $error("saw down clamp wrong"); // see RL10
  property p_tri_up;
    auto_ok && tri_mode && !dir_down_reg && pos_reg <= dv_first && pos_reg < period_reg
      |=> neg_reg == VAL_ONE && pos_adj_reg == $past(dv_first) + VAL_ONE;
  endproperty
  a_tri_up: assert property (p_tri_up) else $error("triangle first-half clamp wrong"); // see RL11
  property p_limit;
    auto_ok && tri_mode && !dir_down_reg && {1'b0, pos_reg} >= {1'b0, period_reg} + {1'b0, dv_first}
      |=> neg_reg == $past(period_reg) - VAL_ONE;
  endproperty
  a_limit: assert property (p_limit) else $error("upper limit not applied"); // see RL14
  property p_protect;
    protect |=> !pwm_neg && $stable(pwm_pos);
  endproperty
  a_protect: assert property (p_protect) else $error("protection did not hold outputs"); // see RL13 RL17
  c_xfer: cover property (xfer_evt && ctrl_reg.buf_first_en && tri_mode);
  c_clamp: cover property (auto_ok && dt_err ##1 dt_err_reg);
  c_protect: cover property (protect ##1 protect);
  c_order: cover property (order_reg);
endmodule
`default_nettype wire

/* pdt_switch_stage.sv */
// Behavioural model of the switching stage fed by the complementary outputs
`default_nettype none
module pdt_switch_stage (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Gate drives from the dead-time unit
  input wire logic pos_drive,
  input wire logic neg_drive,
  // Observations for the bench
  output logic [31:0] overlap_cnt,
  output logic [31:0] neg_on_cnt
);
  timeunit 1ns;
  timeprecision 1ps;
  // ************************************************************
  // Shoot-through and low-side conduction accounting
  // ************************************************************
  // Both switches on in one cycle would short the supply rail
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      overlap_cnt <= '0;
    end else if (pos_drive && neg_drive) begin
      overlap_cnt <= overlap_cnt + 32'h1;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      neg_on_cnt <= '0;
    end else if (neg_drive) begin
      neg_on_cnt <= neg_on_cnt + 32'h1;
    end
  end
endmodule
`default_nettype wire

/* testbench.sv */
// Self-checking bench for the automatic dead-time unit
`default_nettype none
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin num_errors++; \
  $display("[FAIL] %0t: got %h expected %h", $time, got, exp); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import pdt_pkg::*;
  logic pclk, presetn, psel, penable, pwrite;
  pdt_addr_t paddr;
  logic [31:0] pwdata, prdata, q;
  logic pready, pslverr, pwm_pos, pwm_neg, err;
  logic [31:0] overlap_cnt, neg_on_cnt, snap, snap_neg;
  int num_errors = 0;
  int n_checks = 0;
  int cycles = 0;

  pdt_auto_dead_time dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pwm_pos(pwm_pos), .pwm_neg(pwm_neg));
  pdt_switch_stage stage_u (.clk(pclk), .rst_n(presetn), .pos_drive(pwm_pos), .neg_drive(pwm_neg),
    .overlap_cnt(overlap_cnt), .neg_on_cnt(neg_on_cnt));

  // ************************************************************
  // Clock, timeout and closing report
  // ************************************************************
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // The whole sequence needs well under 5000 cycles
  initial begin
    forever begin
      @(posedge pclk);
      cycles++;
      if (cycles > 20000) begin
        num_errors++;
        complete_run();
      end
    end
  end

  // ************************************************************
  // APB master tasks
  // ************************************************************
  task automatic apb_xfer(input logic is_wr, input pdt_addr_t a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= is_wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // Only the bench timeout ends a wait for the answer
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Idle cycles let the negative compare refresh before the next access
  task automatic wr(input pdt_addr_t a, input logic [15:0] v);
    apb_xfer(1'b1, a, {16'h0000, v});
    repeat (3) @(posedge pclk);
  endtask
  task automatic rd_chk(input pdt_addr_t a, input logic [15:0] e);
    apb_xfer(1'b0, a, 32'h0);
    `CHK(q, {16'h0000, e})
  endtask
  function automatic logic [15:0] ctl(input logic [2:0] m, input logic s, input logic b, input logic r);
    pdt_ctrl_s c;
    c = CTRL_RST;
    c.mode = m;
    c.same_sel = s;
    c.buf_first_en = b;
    c.auto_en = 1'b1;
    c.run = r;
    return {7'h00, c};
  endfunction
  task automatic dts(input logic [15:0] p, input logic [15:0] f, input logic [15:0] s);
    wr(OFS_PERIOD, p);
    wr(OFS_DT_FIRST, f);
    wr(OFS_DT_SECOND, s);
  endtask

  // ************************************************************
  // Test sequence
  // ************************************************************
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(OFS_CTRL, 16'h0000);
    `CHK(err, 1'b0)
    rd_chk(OFS_PERIOD, PERIOD_RST);
    rd_chk(OFS_NEG_CMP, VAL_ZERO);
    apb_xfer(1'b0, 8'h28, 32'h0);
    `CHK(err, 1'b1)
    `CHK(q, 32'h0)
    // Saw-wave counting up
    dts(16'h0064, 16'h000a, 16'h000a);
    wr(OFS_POS_CMP, 16'h0032);
    wr(OFS_CTRL, ctl(MODE_SAW_UP, 1'b0, 1'b0, 1'b0));
    rd_chk(OFS_NEG_CMP, 16'h0028);
    wr(OFS_NEG_CMP, 16'h1234);
    rd_chk(OFS_NEG_CMP, 16'h0028);
    wr(OFS_POS_CMP, 16'h0005);
    rd_chk(OFS_NEG_CMP, VAL_ZERO);
    rd_chk(OFS_POS_CMP, 16'h0005);
    apb_xfer(1'b0, OFS_STATUS, 32'h0);
    `CHK(q[1], 1'b1)
    `CHK(q[3], 1'b0)
    wr(OFS_POS_CMP, 16'h005f);
    rd_chk(OFS_NEG_CMP, 16'h0064);
    // Saw-wave counting down, separate and shared dead times
    wr(OFS_CTRL, ctl(MODE_SAW_DN, 1'b0, 1'b0, 1'b0));
    rd_chk(OFS_NEG_CMP, 16'h0064);
    wr(OFS_POS_CMP, 16'h0032);
    rd_chk(OFS_NEG_CMP, 16'h003c);
    wr(OFS_DT_SECOND, 16'h001e);
    wr(OFS_POS_CMP, 16'h0019);
    rd_chk(OFS_NEG_CMP, VAL_ZERO);
    wr(OFS_CTRL, ctl(MODE_SAW_DN, 1'b1, 1'b0, 1'b0));
    rd_chk(OFS_NEG_CMP, 16'h0023);
    // Triangle modes, stopped counter sits in the up-count half
    for (int m = 0; m < 3; m++) begin
      wr(OFS_CTRL, ctl(MODE_TRI1 + 3'(m), 1'b0, 1'b0, 1'b0));
      dts(16'h0064, 16'h000a, 16'h0014);
      wr(OFS_POS_CMP, 16'h0032);
      rd_chk(OFS_NEG_CMP, 16'h0028);
      wr(OFS_POS_CMP, 16'h000a);
      rd_chk(OFS_NEG_CMP, VAL_ONE);
      wr(OFS_POS_CMP, 16'h0096);
      rd_chk(OFS_NEG_CMP, 16'h0063);
    end
    // Outside the listed modes the negative compare is plain storage
    wr(OFS_CTRL, ctl(3'h5, 1'b0, 1'b0, 1'b0));
    wr(OFS_NEG_CMP, 16'h1234);
    rd_chk(OFS_NEG_CMP, 16'h1234);
    // Dead times that together exceed the cycle in saw mode
    wr(OFS_CTRL, ctl(MODE_SAW_UP, 1'b0, 1'b0, 1'b0));
    dts(16'h0064, 16'h003c, 16'h003c);
    wr(OFS_POS_CMP, 16'h0032);
    apb_xfer(1'b0, OFS_STATUS, 32'h0);
    `CHK(q[3], 1'b1)
    // Buffer transfer at the saw cycle end
    dts(16'h0014, 16'h0002, 16'h0002);
    wr(OFS_POS_CMP, 16'h000a);
    wr(OFS_DT_FIRST_BUF, 16'h0004);
    rd_chk(OFS_DT_FIRST, 16'h0002);
    wr(OFS_CTRL, ctl(MODE_SAW_UP, 1'b0, 1'b1, 1'b1));
    repeat (40) @(posedge pclk);
    rd_chk(OFS_DT_FIRST, 16'h0004);
    rd_chk(OFS_NEG_CMP, 16'h0006);
    // Running triangle: dead time keeps the switches apart, then protection
    wr(OFS_CTRL, ctl(MODE_TRI1, 1'b0, 1'b0, 1'b0));
    wr(OFS_DT_FIRST, 16'h0002);
    snap = overlap_cnt;
    snap_neg = neg_on_cnt;
    wr(OFS_CTRL, ctl(MODE_TRI1, 1'b0, 1'b0, 1'b1));
    repeat (120) @(posedge pclk);
    `CHK(overlap_cnt, snap)
    `CHK(neg_on_cnt != snap_neg, 1'b1)
    wr(OFS_POS_CMP, VAL_ZERO);
    snap = neg_on_cnt;
    repeat (60) @(posedge pclk);
    `CHK(neg_on_cnt, snap)
    apb_xfer(1'b0, OFS_STATUS, 32'h0);
    `CHK(q[2], 1'b1)
    complete_run();
  end
endmodule
`default_nettype wire
